// ### xcvr_map.svh
// constants for the registered octal bus transceiver
`ifndef XCVR_MAP_SVH
`define XCVR_MAP_SVH
`define WORD_W 8
`define LOG_DEPTH 4
`define DRIVE_OFF_RESET 1'h0
`endif

// ### xcvr_pkg.sv
// types shared by the transceiver
`default_nettype none
`include "xcvr_map.svh"
package xcvr_pkg;
    typedef logic [`WORD_W-1:0] word_t;
    typedef enum logic [1:0] {
        MODE_ISOLATE,
        MODE_A_TO_B,
        MODE_B_TO_A,
        MODE_BOTH
    } drive_mode_t;
endpackage : xcvr_pkg
`default_nettype wire

// ### bus_xcvr.sv
// registered octal bus transceiver with capture log fifo
`timescale 1ns/10ps
`default_nettype none
`include "xcvr_map.svh"

module capture_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = `LOG_DEPTH
) (
    input wire logic clk,               // system clock
    input wire logic rst,               // sync reset, high
    input wire logic in_valid,          // push request
    output logic in_ready,              // room for a word
    input wire logic [WIDTH-1:0] in_data, // pushed word
    output logic out_valid,             // word available
    input wire logic out_ready,         // consumer takes word
    output logic [WIDTH-1:0] out_data   // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                              : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                              : rd_ptr_reg + AW'(1);
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : capture_fifo

module bus_xcvr #(
    parameter int WIDTH = `WORD_W
) (
    input wire logic clk,                        // 100 MHz clock
    input wire logic rst,                        // sync reset, high
    input wire logic [WIDTH-1:0] a_in,           // port a pin level
    output logic [WIDTH-1:0] a_out,              // port a drive value
    output logic a_oe,                           // port a driven
    input wire logic [WIDTH-1:0] b_in,           // port b pin level
    output logic [WIDTH-1:0] b_out,              // port b drive value
    output logic b_oe,                           // port b driven
    input wire logic a_capture_clock,            // loads a register
    input wire logic b_capture_clock,            // loads b register
    input wire logic b_side_drive_enable,        // high drives b
    input wire logic a_side_drive_enable_n,      // low drives a
    input wire logic b_out_source_select,        // 1: stored a to b
    input wire logic a_out_source_select,        // 1: stored b to a
    output logic [WIDTH-1:0] a_stored_word,      // a storage register
    output logic [WIDTH-1:0] b_stored_word,      // b storage register
    output xcvr_pkg::drive_mode_t bus_mode,      // current drive mode
    output logic log_valid,                      // capture log word
    input wire logic log_ready,                  // log consumer ready
    output logic log_a_hit,                      // entry holds a capture
    output logic log_b_hit,                      // entry holds b capture
    output logic [WIDTH-1:0] log_a_word,         // captured a word
    output logic [WIDTH-1:0] log_b_word,         // captured b word
    output logic log_space                       // log can take a word
);
    localparam int LW = 2 + 2 * WIDTH;
    // pins are asynchronous: two flops before use
    logic [WIDTH-1:0] a_s1, a_s2, b_s1, b_s2;
    logic [5:0] ctl_s1, ctl_s2;
    logic ca_s3, cb_s3;
    logic ca_edge, cb_edge;
    logic [WIDTH-1:0] a_store_next, b_store_next;
    logic f_in_ready, f_out_valid;
    logic [LW-1:0] f_out_data;
    logic log_take;

    always_ff @(posedge clk) begin
        a_s1 <= a_in;
        b_s1 <= b_in;
        ctl_s1 <= {a_capture_clock, b_capture_clock, b_side_drive_enable,
                   a_side_drive_enable_n, b_out_source_select,
                   a_out_source_select};
        a_s2 <= a_s1;
        b_s2 <= b_s1;
        ctl_s2 <= ctl_s1;
        ca_s3 <= ctl_s2[5];
        cb_s3 <= ctl_s2[4];
    end

    // data and clock share sync depth, so setup at the pins carries over
    // rising edge detect
    assign ca_edge = ctl_s2[5] && !ca_s3;
    assign cb_edge = ctl_s2[4] && !cb_s3;
    assign a_store_next = ca_edge ? a_s2 : a_stored_word;
    assign b_store_next = cb_edge ? b_s2 : b_stored_word;

    always_ff @(posedge clk) begin
        a_stored_word <= a_store_next;
        b_stored_word <= b_store_next;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            b_oe <= `DRIVE_OFF_RESET;
            a_oe <= `DRIVE_OFF_RESET;
        end else begin
            b_oe <= ctl_s2[3];
            a_oe <= !ctl_s2[2];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_mode <= xcvr_pkg::MODE_ISOLATE;
        end else begin
            case ({ctl_s2[3], !ctl_s2[2]})
                2'h0: bus_mode <= xcvr_pkg::MODE_ISOLATE;
                2'h1: bus_mode <= xcvr_pkg::MODE_B_TO_A;
                2'h2: bus_mode <= xcvr_pkg::MODE_A_TO_B;
                default: bus_mode <= xcvr_pkg::MODE_BOTH;
            endcase
        end
    end

    // source selects, new word shows at once
    always_ff @(posedge clk) begin
        b_out <= ctl_s2[1] ? a_store_next : a_s2;
        a_out <= ctl_s2[0] ? b_store_next : b_s2;
    end

    // a full log drops captures; the pins cannot be stalled
    capture_fifo #(.WIDTH(LW), .DEPTH(`LOG_DEPTH)) u_log (
        .clk(clk),
        .rst(rst),
        .in_valid(ca_edge || cb_edge),
        .in_ready(f_in_ready),
        .in_data({ca_edge, cb_edge, a_s2, b_s2}),
        .out_valid(f_out_valid),
        .out_ready(log_take),
        .out_data(f_out_data)
    );

    // output stage is a one-word pipeline holding register; log_ready reaches the fifo pop directly
    assign log_take = f_out_valid && (!log_valid || log_ready);

    always_ff @(posedge clk) begin
        if (rst) begin
            log_valid <= 1'h0;
            log_space <= 1'h0;
            log_a_hit <= 1'h0;
            log_b_hit <= 1'h0;
            log_a_word <= '0;
            log_b_word <= '0;
        end else begin
            log_space <= f_in_ready;
            if (log_take) begin
                log_valid <= 1'h1;
                {log_a_hit, log_b_hit, log_a_word, log_b_word} <= f_out_data;
            end else if (log_ready) begin
                log_valid <= 1'h0;
            end
        end
    end

    default clocking cb_main @(posedge clk); endclocking
    default disable iff (rst);

    AST_A_LOAD: assert property (
        ca_edge |=> a_stored_word == $past(a_s2))
        else $error("a register missed a capture");
    AST_B_HOLD: assert property (
        !cb_edge |=> $stable(b_stored_word))
        else $error("b register changed without edge");
    AST_B_DRIVE: assert property (
        !$past(rst, 3) |-> b_oe == $past(b_side_drive_enable, 3))
        else $error("b drive enable wrong");
    AST_ISOLATE: assert property (
        bus_mode == xcvr_pkg::MODE_ISOLATE |-> !a_oe && !b_oe)
        else $error("port driven in isolation");
    AST_B_LIVE: assert property (
        !ctl_s2[1] |=> b_out == $past(a_s2))
        else $error("b not live a");
    AST_A_STORED: assert property (
        ctl_s2[0] |=> a_out == b_stored_word)
        else $error("a not stored b");
    AST_NEW_WORD: assert property (
        ctl_s2[1] && ca_edge |=> b_out == a_stored_word
            && a_stored_word == $past(a_s2))
        else $error("stored path missed new word");
    AST_BOTH: assert property (
        ctl_s2[1] && ctl_s2[0] |=> b_out == a_stored_word
            && a_out == b_stored_word)
        else $error("dual stored transfer wrong");
    AST_LIVE_STORE: assert property (
        !ctl_s2[1] && ca_edge |=> b_out == a_stored_word)
        else $error("live store differs from live path");

    COV_STORE_BOTH: cover property (ca_edge && cb_edge);
    COV_DUAL: cover property (bus_mode == xcvr_pkg::MODE_BOTH
        && ctl_s2[1] && ctl_s2[0]);
    COV_LOG_FULL: cover property (!f_in_ready);
endmodule : bus_xcvr
`default_nettype wire

// ### bus_far.sv
// far-side parties that drive ports a and b when the device releases them
`timescale 1ns/10ps
`default_nettype none
module bus_far (
    input wire logic [7:0] a_out, // device drive on a
    input wire logic a_oe,        // device drives a
    input wire logic [7:0] b_out, // device drive on b
    input wire logic b_oe,        // device drives b
    input wire logic [7:0] a_word, // far word for a
    input wire logic [7:0] b_word, // far word for b
    output logic [7:0] a_in,      // resolved a wire
    output logic [7:0] b_in       // resolved b wire
);
    // far party holds a settled word on a released port
    assign a_in = a_oe ? a_out : a_word;
    assign b_in = b_oe ? b_out : b_word;
endmodule : bus_far
`default_nettype wire

// ### bus_xcvr_test.sv
// self-checking bench for the registered bus transceiver
`timescale 1ns/10ps
`default_nettype none
module bus_xcvr_test;
    logic clk = 0, rst = 1, ca = 0, cb = 0, ben = 0, aen_n = 1, hold = 0;
    logic sb = 0, sa = 0, lrdy = 1, aoe, boe, lv, lha, lhb, lsp;
    logic [7:0] aw = 8'h00, bw = 8'h00, ai, bi, ao, bo, qa, qb, la, lb;
    logic [7:0] ea, eb;
    xcvr_pkg::drive_mode_t bm;
    logic [17:0] q[$];
    logic [17:0] ex;
    logic [31:0] rs = 32'hD618B08F, ls = 32'hD618B08F;
    int failures = 0, cmp_count = 0;
    always #5 clk = ~clk;
    bus_xcvr dut_u (.clk(clk), .rst(rst), .a_in(ai), .a_out(ao),
        .a_oe(aoe), .b_in(bi), .b_out(bo), .b_oe(boe),
        .a_capture_clock(ca), .b_capture_clock(cb),
        .b_side_drive_enable(ben), .a_side_drive_enable_n(aen_n),
        .b_out_source_select(sb), .a_out_source_select(sa),
        .a_stored_word(qa), .b_stored_word(qb), .bus_mode(bm),
        .log_valid(lv), .log_ready(lrdy), .log_a_hit(lha),
        .log_b_hit(lhb), .log_a_word(la), .log_b_word(lb),
        .log_space(lsp));
    bus_far far_u (.a_out(ao), .a_oe(aoe), .b_out(bo), .b_oe(boe),
        .a_word(aw), .b_word(bw), .a_in(ai), .b_in(bi));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task test_done;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic mode(input logic e_b, e_an, s_b, s_a);
        xcvr_pkg::drive_mode_t em;
        @(posedge clk);
        ben <= e_b;
        aen_n <= e_an;
        sb <= s_b;
        sa <= s_a;
        repeat (8) @(posedge clk);
        chk({7'h00, boe}, {7'h00, e_b});
        chk({7'h00, aoe}, {7'h00, ~e_an});
        em = e_b ? (e_an ? xcvr_pkg::MODE_A_TO_B : xcvr_pkg::MODE_BOTH)
            : (e_an ? xcvr_pkg::MODE_ISOLATE : xcvr_pkg::MODE_B_TO_A);
        chk({6'h00, bm}, {6'h00, em});
    endtask : mode
    // words settle first
    // a driven port follows the far word three cycles late, so wait longer
    task automatic cap(input logic c_a, c_b, logit);
        rs = xs(rs);
        @(posedge clk);
        if (!aoe) aw <= rs[7:0];
        if (!boe) bw <= rs[15:8];
        repeat (5) @(posedge clk);
        ca <= c_a;
        cb <= c_b;
        repeat (3) @(posedge clk);
        ca <= 1'b0;
        cb <= 1'b0;
        if (c_a) ea = ai;
        if (c_b) eb = bi;
        if (logit) q.push_back({c_a, c_b, ai, bi});
        repeat (6) @(posedge clk);
    endtask : cap
    task automatic look;
        chk(qa, ea);
        chk(qb, eb);
        if (boe) chk(bo, sb ? ea : aw);
        if (aoe) chk(ao, sa ? eb : bw);
    endtask : look
    always @(posedge clk) begin
        ls = xs(ls);
        lrdy <= !hold && (ls[0] | ls[1]);
        if (!rst && lv === 1'b1 && lrdy) begin
            if (q.size() == 0) chk(8'h01, 8'h00);
            else begin
                ex = q.pop_front();
                chk({6'h00, lha, lhb}, {6'h00, ex[17:16]});
                if (ex[17]) chk(la, ex[15:8]);
                if (ex[16]) chk(lb, ex[7:0]);
            end
        end
    end
    initial begin
        #100000;
        failures++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        mode(0, 1, 0, 0);
        cap(1, 0, 1);
        cap(0, 1, 1);
        cap(1, 1, 1);
        look();
        mode(1, 1, 0, 0);
        cap(1, 0, 1);
        look();
        cap(1, 1, 1);
        look();
        mode(1, 1, 1, 0);
        cap(1, 0, 1);
        look();
        mode(0, 0, 0, 0);
        cap(0, 1, 1);
        look();
        cap(1, 1, 1);
        look();
        mode(0, 0, 0, 1);
        cap(0, 1, 1);
        look();
        mode(1, 0, 1, 1);
        look();
        mode(1, 0, 0, 0);
        // stall the log consumer: five entries fill it, a sixth is dropped
        mode(0, 1, 0, 0);
        hold <= 1'b1;
        repeat (5) cap(1, 0, 1);
        chk({7'h00, lsp}, 8'h00);
        cap(0, 1, 0);
        look();
        hold <= 1'b0;
        repeat (40) @(posedge clk);
        chk(8'(q.size()), 8'h00);
        chk({7'h00, lsp}, 8'h01);
        test_done;
    end
endmodule : bus_xcvr_test
`default_nettype wire
